//--- gpio_port_pkg.sv
// Register map, field positions and reset values of the six-bit port
package gpio_port_pkg;

    localparam int unsigned PORT_W      = 6;
    localparam int unsigned ADDR_W      = 5;
    localparam int unsigned DATA_W      = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_DATA     = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION    = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PULLUP_EN    = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CHANGE_EN    = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL  = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_CONFIG       = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_SEL   = 5'h18;

    // Pin positions
    localparam int unsigned INPUT_ONLY_BIT = 3;
    localparam int unsigned REF_OUT_BIT    = 1;
    localparam int unsigned OSC_PIN_LO     = 4;
    localparam int unsigned OSC_PIN_HI     = 5;

    // interrupt_control fields
    localparam int unsigned IC_FLAG_BIT    = 0;
    localparam int unsigned IC_CHG_IE_BIT  = 1;
    localparam int unsigned IC_GIE_BIT     = 2;

    // Configuration fields
    localparam int unsigned CF_PU_DIS_BIT  = 0;
    localparam int unsigned CF_MASTER_CLEAR_ENABLE_BIT   = 1;
    localparam int unsigned CF_XTAL_BIT    = 2;
    localparam int unsigned CF_VREF_BIT    = 3;

    // Reset values
    localparam logic [PORT_W-1:0] DIR_RESET     = 6'h3F;
    localparam logic [PORT_W-1:0] PULLUP_RESET  = 6'h3F;
    localparam logic [PORT_W-1:0] CHANGE_RESET  = 6'h00;
    localparam logic [PORT_W-1:0] ANALOG_RESET  = 6'h3F;
    localparam logic [PORT_W-1:0] LATCH_RESET   = 6'h00;
    localparam logic              PU_DIS_RESET  = 1'h1;
    localparam logic              MASTER_CLEAR_ENABLE_RESET   = 1'h0;
    localparam logic              XTAL_RESET    = 1'h0;
    localparam logic              VREF_RESET    = 1'h0;

    // Mask of the two oscillator pins
    localparam logic [PORT_W-1:0] OSC_PIN_MASK  = 6'h30;

endpackage

//--- gpio_port.sv
// Six-bit port, bidirectional except input-only pin 3, with pull-ups and change detector, Avalon-MM slave
`timescale 1ns/1ps

module gpio_port
    import gpio_port_pkg::*;
(
    // Clock and resets
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                soft_reset,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]   address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [DATA_W-1:0]   writedata,
    input  wire logic [3:0]          byteenable,
    output logic      [DATA_W-1:0]   readdata,
    output logic                     waitrequest,
    // Port pins
    input  wire logic [PORT_W-1:0]   pin_in,
    output logic      [PORT_W-1:0]   pin_out,
    output logic      [PORT_W-1:0]   pin_oe_n,
    output logic      [PORT_W-1:0]   pullup_on,
    // Events
    output logic                     change_irq,
    output logic                     wake_request
);

    typedef struct packed {
        logic [PORT_W-1:0] sync1;
        logic [PORT_W-1:0] sync2;
        logic [PORT_W-1:0] latch;
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] pu_en;
        logic [PORT_W-1:0] chg_en;
        logic [PORT_W-1:0] cmp;
        logic [PORT_W-1:0] analog;
        logic              flag;
        logic              chg_ie;
        logic              global_irq_enable;
        logic              pu_dis;
        logic              master_clear_enable;
        logic              xtal;
        logic              vref_out;
        logic              wait_r;
        logic [DATA_W-1:0] rdata;
        logic [PORT_W-1:0] pout;
        logic [PORT_W-1:0] oe_n;
        logic [PORT_W-1:0] pu_on;
        logic              irq;
        logic              wake;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Crystal modes force the oscillator pins to read 1 in the direction, pull-up and change-enable registers
    function automatic logic [PORT_W-1:0] osc_force(input logic [PORT_W-1:0] v, input logic xtal);
        osc_force = xtal ? (v | OSC_PIN_MASK) : v;
    endfunction

    // Pin level as software sees it
    function automatic logic [PORT_W-1:0] pin_view(input logic [PORT_W-1:0] lvl,
                                                   input logic [PORT_W-1:0] ana,
                                                   input logic              master_clear_enable);
        logic [PORT_W-1:0] v;
        v = lvl & ~ana;
        if (master_clear_enable) begin
            v[INPUT_ONLY_BIT] = 1'b0;
        end
        pin_view = v;
    endfunction

    logic [PORT_W-1:0] dir_view;
    logic [PORT_W-1:0] mismatch;
    logic              take;
    logic              port_hit;

    always_comb begin
        dir_view                 = osc_force(s_q.dir, s_q.xtal);
        dir_view[INPUT_ONLY_BIT] = 1'b1;
        mismatch = (s_q.sync2 ^ s_q.cmp) & s_q.chg_en;
        take     = (read | write) & ~s_q.wait_r;
        port_hit = take & (address == OFS_PIN_DATA);
    end

    always_comb begin
        s_d = s_q;
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;

        // Bus: waitrequest drops for one cycle after a request is seen
        s_d.wait_r = 1'b1;
        if ((read | write) & s_q.wait_r) begin
            s_d.wait_r = 1'b0;
            s_d.rdata  = '0;
            unique case (address)
                OFS_PIN_DATA:    s_d.rdata[PORT_W-1:0] = pin_view(s_q.sync2, s_q.analog, s_q.master_clear_enable);
                OFS_DIRECTION:   s_d.rdata[PORT_W-1:0] = dir_view;
                OFS_PULLUP_EN:   s_d.rdata[PORT_W-1:0] = osc_force(s_q.pu_en, s_q.xtal);
                OFS_CHANGE_EN:   s_d.rdata[PORT_W-1:0] = osc_force(s_q.chg_en, s_q.xtal);
                OFS_IRQ_CONTROL: begin
                    s_d.rdata[IC_FLAG_BIT]   = s_q.flag;
                    s_d.rdata[IC_CHG_IE_BIT] = s_q.chg_ie;
                    s_d.rdata[IC_GIE_BIT]    = s_q.global_irq_enable;
                end
                OFS_CONFIG: begin
                    s_d.rdata[CF_PU_DIS_BIT] = s_q.pu_dis;
                    s_d.rdata[CF_MASTER_CLEAR_ENABLE_BIT]  = s_q.master_clear_enable;
                    s_d.rdata[CF_XTAL_BIT]   = s_q.xtal;
                    s_d.rdata[CF_VREF_BIT]   = s_q.vref_out;
                end
                OFS_ANALOG_SEL:  s_d.rdata[PORT_W-1:0] = s_q.analog;
                default:         s_d.rdata = '0;
            endcase
        end

        // Writes take effect at the edge where waitrequest is seen low
        if (take & write & byteenable[0]) begin
            unique case (address)
                OFS_PIN_DATA:    s_d.latch  = writedata[PORT_W-1:0];
                OFS_DIRECTION:   s_d.dir    = writedata[PORT_W-1:0];
                OFS_PULLUP_EN:   s_d.pu_en  = writedata[PORT_W-1:0];
                OFS_CHANGE_EN:   s_d.chg_en = writedata[PORT_W-1:0];
                OFS_IRQ_CONTROL: begin
                    s_d.flag   = writedata[IC_FLAG_BIT] & s_q.flag;
                    s_d.chg_ie = writedata[IC_CHG_IE_BIT];
                    s_d.global_irq_enable    = writedata[IC_GIE_BIT];
                end
                OFS_CONFIG: begin
                    s_d.pu_dis   = writedata[CF_PU_DIS_BIT];
                    s_d.master_clear_enable    = writedata[CF_MASTER_CLEAR_ENABLE_BIT];
                    s_d.xtal     = writedata[CF_XTAL_BIT];
                    s_d.vref_out = writedata[CF_VREF_BIT];
                end
                OFS_ANALOG_SEL:  s_d.analog = writedata[PORT_W-1:0];
                default: ;
            endcase
        end

        // Any access to the port reloads the comparison value
        if (port_hit) begin
            s_d.cmp = s_q.sync2;
        end

        // Set wins over a clear in the same cycle; a miss during the reload is tolerated
        if (|mismatch) begin
            s_d.flag = 1'b1;
        end

        // Master-clear and brown-out: all register fields but the comparison value return to reset, except the flag, which takes the current mismatch
        if (soft_reset) begin
            s_d.latch    = LATCH_RESET;
            s_d.dir      = DIR_RESET;
            s_d.pu_en    = PULLUP_RESET;
            s_d.chg_en   = CHANGE_RESET;
            s_d.analog   = ANALOG_RESET;
            s_d.flag     = |mismatch;
            s_d.chg_ie   = 1'b0;
            s_d.global_irq_enable      = 1'b0;
            s_d.pu_dis   = PU_DIS_RESET;
            s_d.master_clear_enable    = MASTER_CLEAR_ENABLE_RESET;
            s_d.xtal     = XTAL_RESET;
            s_d.vref_out = VREF_RESET;
        end

        // Pin drivers and pull-ups
        s_d.pout = s_q.latch;
        s_d.oe_n = s_q.dir;
        s_d.oe_n[INPUT_ONLY_BIT] = 1'b1;
        if (s_q.vref_out) begin
            s_d.oe_n[REF_OUT_BIT] = 1'b1;
        end
        s_d.pu_on = s_q.pu_en & s_q.dir & {PORT_W{~s_q.pu_dis}};
        s_d.pu_on[INPUT_ONLY_BIT] = s_q.master_clear_enable |
            (s_q.pu_en[INPUT_ONLY_BIT] & ~s_q.pu_dis);

        s_d.irq  = s_q.flag & s_q.chg_ie & s_q.global_irq_enable;
        s_d.wake = |mismatch;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.sync1    <= '0;
            s_q.sync2    <= '0;
            s_q.latch    <= LATCH_RESET;
            s_q.dir      <= DIR_RESET;
            s_q.pu_en    <= PULLUP_RESET;
            s_q.chg_en   <= CHANGE_RESET;
            s_q.cmp      <= '0;
            s_q.analog   <= ANALOG_RESET;
            s_q.flag     <= 1'b0;
            s_q.chg_ie   <= 1'b0;
            s_q.global_irq_enable      <= 1'b0;
            s_q.pu_dis   <= PU_DIS_RESET;
            s_q.master_clear_enable    <= MASTER_CLEAR_ENABLE_RESET;
            s_q.xtal     <= XTAL_RESET;
            s_q.vref_out <= VREF_RESET;
            s_q.wait_r   <= 1'b1;
            s_q.rdata    <= '0;
            s_q.pout     <= '0;
            s_q.oe_n     <= '1;
            s_q.pu_on    <= '0;
            s_q.irq      <= 1'b0;
            s_q.wake     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign readdata     = s_q.rdata;
    assign waitrequest  = s_q.wait_r;
    assign pin_out      = s_q.pout;
    assign pin_oe_n     = s_q.oe_n;
    assign pullup_on    = s_q.pu_on;
    assign change_irq   = s_q.irq;
    assign wake_request = s_q.wake;

endmodule // gpio_port

//--- gpio_port_monitor.sv
// Bus and pin property checks for the six-bit port
`timescale 1ns/1ps
module gpio_port_monitor
    import gpio_port_pkg::*;
(
    // Clock and resets
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              soft_reset,
    // Bus
    input wire logic              read,
    input wire logic              write,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic              waitrequest,
    // Pins and events
    input wire logic [PORT_W-1:0] pin_oe_n,
    input wire logic [PORT_W-1:0] pullup_on,
    input wire logic              change_irq,
    input wire logic              wake_request
);
    logic wr_done;
    assign wr_done = write && !waitrequest;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_wait_one: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("waitrequest low beyond one cycle");
    chk_take_req: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    chk_idle_wait: assert property (!(read || write) && waitrequest |=> waitrequest)
        else $error("answer without a request");
    chk_pin3_float: assert property (pin_oe_n[INPUT_ONLY_BIT])
        else $error("input-only pin driven");
    chk_pu_out: assert property ((~pin_oe_n & pullup_on) == '0)
        else $error("pull-up on a driven pin");
    chk_rd_upper: assert property (read && !waitrequest |-> readdata[DATA_W-1:PORT_W] == '0)
        else $error("unimplemented read bits set");
    chk_oe_cause: assert property ($changed(pin_oe_n) |-> $past(wr_done, 2) || $past(soft_reset, 2))
        else $error("driver enable changed without a write");
    chk_irq_fall: assert property ($fell(change_irq) |-> $past(wr_done, 2) || $past(soft_reset, 2))
        else $error("interrupt dropped without a write");
    cov_read: cover property (read && !waitrequest);
    cov_wake: cover property ($rose(wake_request));
    cov_irq: cover property ($rose(change_irq));
endmodule // gpio_port_monitor

bind gpio_port gpio_port_monitor gpio_port_monitor_inst (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .pin_oe_n(pin_oe_n),
    .pullup_on(pullup_on), .change_irq(change_irq), .wake_request(wake_request));

//--- gpio_board_model.sv
// Board model resolving pin levels from drivers, pull-ups and external sources
`timescale 1ns/1ps
module gpio_board_model
    import gpio_port_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Device side
    input  wire logic [PORT_W-1:0] pin_out,
    input  wire logic [PORT_W-1:0] pin_oe_n,
    input  wire logic [PORT_W-1:0] pullup_on,
    // External sources
    input  wire logic [PORT_W-1:0] ext_val,
    input  wire logic [PORT_W-1:0] ext_en,
    // Levels seen by the device
    output logic      [PORT_W-1:0] pin_in
);
    logic [PORT_W-1:0] flt_q = '0;
    // A floating pin wanders so no settled value passes for a driven one
    always @(posedge clk) flt_q <= ~flt_q;
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pullup_on[i]) pin_in[i] = 1'b1;
            else pin_in[i] = flt_q[i];
        end
    end
endmodule // gpio_board_model

//--- gpio_port_tb_top.sv
// Register-level test sequence for the six-bit port
`timescale 1ns/1ps
module gpio_port_tb_top
    import gpio_port_pkg::*;
;
    logic clk = 0, arst_n = 0, soft_reset = 0, read = 0, write = 0, change_irq, wake_request, waitrequest;
    logic [ADDR_W-1:0] address = '0;
    logic [DATA_W-1:0] writedata = '0, readdata, q;
    logic [PORT_W-1:0] pin_in, pin_out, pin_oe_n, pullup_on, ext_val = 6'h35;
    int fails = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    gpio_port gpio_port_inst (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .change_irq(change_irq), .wake_request(wake_request));
    gpio_board_model gpio_board_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(6'h3F), .pin_in(pin_in));
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        if (w) write <= 1'b1;
        else read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 20);
        q = readdata;
        if (n >= 20) begin
            fails++;
            $display("ERROR %0t bus answer missing", $time);
        end
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        acc(1'b0, a, '0);
        cmp(q, exp);
    endtask
    // Output is picked after the wait so the value seen is the one standing at that edge
    task automatic pins(input int n, input int sel, input logic [PORT_W-1:0] e);
        logic [PORT_W-1:0] v;
        repeat (n) @(posedge clk);
        case (sel)
            0: v = pullup_on;
            1: v = pin_oe_n;
            2: v = pin_out;
            3: v = {5'h0, wake_request};
            default: v = {5'h0, change_irq};
        endcase
        cmp({26'h0, v}, {26'h0, e});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rdc(OFS_DIRECTION, 32'h3F);
        rdc(OFS_PULLUP_EN, 32'h3F);
        rdc(OFS_CHANGE_EN, 32'h00);
        rdc(OFS_CONFIG, 32'h01);
        rdc(OFS_PIN_DATA, 32'h00);
        pins(0, 0, 6'h00);
        rdc(5'h1C, 32'h00);
        acc(1'b1, OFS_ANALOG_SEL, 32'h0);
        acc(1'b1, OFS_CONFIG, 32'h0);
        pins(3, 0, 6'h3F);
        rdc(OFS_PIN_DATA, 32'h35);
        acc(1'b1, OFS_DIRECTION, 32'hFFFFFFC0);
        acc(1'b1, OFS_PIN_DATA, 32'hFFFFFF2A);
        pins(3, 1, 6'h08);
        pins(0, 0, 6'h08);
        pins(0, 2, 6'h2A);
        rdc(OFS_PIN_DATA, 32'h22);
        rdc(OFS_DIRECTION, 32'h08);
        acc(1'b1, OFS_CONFIG, 32'h8);
        pins(3, 1, 6'h0A);
        rdc(OFS_DIRECTION, 32'h08);
        rdc(OFS_PIN_DATA, 32'h20);
        acc(1'b1, OFS_ANALOG_SEL, 32'h20);
        rdc(OFS_PIN_DATA, 32'h00);
        acc(1'b1, OFS_ANALOG_SEL, 32'h0);
        ext_val <= 6'h3D;
        acc(1'b1, OFS_CONFIG, 32'h2);
        acc(1'b1, OFS_PULLUP_EN, 32'h0);
        pins(3, 0, 6'h08);
        rdc(OFS_PIN_DATA, 32'h22);
        acc(1'b1, OFS_CONFIG, 32'h4);
        rdc(OFS_DIRECTION, 32'h38);
        rdc(OFS_PULLUP_EN, 32'h30);
        rdc(OFS_CHANGE_EN, 32'h30);
        acc(1'b1, OFS_CONFIG, 32'h0);
        ext_val <= 6'h3C;
        acc(1'b1, OFS_DIRECTION, 32'h3F);
        acc(1'b1, OFS_CHANGE_EN, 32'h01);
        repeat (4) @(posedge clk);
        rdc(OFS_PIN_DATA, 32'h3C);
        rdc(OFS_IRQ_CONTROL, 32'h0);
        ext_val <= 6'h3D;
        pins(5, 3, 6'h01);
        rdc(OFS_IRQ_CONTROL, 32'h1);
        acc(1'b1, OFS_IRQ_CONTROL, 32'h2);
        pins(3, 4, 6'h00);
        rdc(OFS_IRQ_CONTROL, 32'h3);
        acc(1'b1, OFS_IRQ_CONTROL, 32'h6);
        pins(3, 4, 6'h01);
        rdc(OFS_PIN_DATA, 32'h3D);
        acc(1'b1, OFS_IRQ_CONTROL, 32'h6);
        pins(3, 4, 6'h00);
        ext_val <= 6'h3C;
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        acc(1'b1, OFS_ANALOG_SEL, 32'h0);
        acc(1'b1, OFS_CHANGE_EN, 32'h01);
        repeat (4) @(posedge clk);
        rdc(OFS_IRQ_CONTROL, 32'h1);
        test_done();
    end
    initial begin
        #50000;
        fails++;
        $display("ERROR %0t run did not finish", $time);
        test_done();
    end
endmodule // gpio_port_tb_top
